// file: pkg/tmrtog_pkg.sv
`default_nettype none
package tmrtog_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_CFG = 3'h1;
	localparam logic [2:0] OFF_RLD_LO = 3'h2;
	localparam logic [2:0] OFF_RLD_HI = 3'h3;
	localparam logic [2:0] OFF_CNT_LO = 3'h4;
	localparam logic [2:0] OFF_CNT_HI = 3'h5;
	// timer_control_reg fields
	localparam int CTRL_RUN = 2;
	localparam int CTRL_TC_SEL = 1;
	localparam int CTRL_CR_SEL = 0;
	localparam int CTRL_OVF = 7;
	// timer_config_reg fields
	localparam int CFG_DOWN = 0;
	localparam int CFG_OUT_EN = 1;
	localparam int CFG_TOG = 2;
	localparam logic [15:0] CNT_TOP = 16'hFFFF;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] RLD_RST = 16'h0000;
endpackage
`default_nettype wire

// file: design/tmrtog_edge.sv
`default_nettype none
// Computes next count and wrap event for one timer tick
module tmrtog_edge
	import tmrtog_pkg::*;
(
	input wire logic [15:0] count_i,
	input wire logic [15:0] reload_i,
	input wire logic down_i,
	output logic [15:0] count_next_o,
	output logic wrap_o
);
	always_comb begin
		if (down_i) begin
			// [R3] Underflow on reload match
			wrap_o = (count_i == reload_i);
			count_next_o = wrap_o ? CNT_TOP : 16'(count_i - 16'h0001);
		end else begin
			// [R4] Overflow reloads value
			wrap_o = (count_i == CNT_TOP);
			count_next_o = wrap_o ? reload_i : 16'(count_i + 16'h0001);
		end
	end
endmodule
`default_nettype wire

// file: design/tmrtog_top.sv
// Design decisions made here: the strobed register port and the address map.
`default_nettype none
// How it works
// [R1] Dedicated pin toggles, 50% duty square wave
// [R2] Invert on overflow up, underflow down
// [R3] Down: reload 0xFFFF, underflow at reload
// [R4] Up: reload value, overflow past 0xFFFF
// [R5] Software clears select bits for reload
// [R6] Pin driven only with output enable
// [R7] Frequency is clock over 2*(65536-reload)
// [R8] Run bit starts counting and toggling
// [R9] Config bit 2 reads/forces toggle level
// [R10] Stopped timer holds toggle level
module tmrtog_top
	import tmrtog_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic toggle_pin_a_o,
	output logic toggle_pin_a_oe_o
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] cfg_reg, cfg_next;
	logic [15:0] rld_reg, rld_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [7:0] rdata_reg, rdata_next;
	logic pin_reg, pin_next;
	logic oe_reg, oe_next;
	logic [15:0] step_cnt;
	logic wrap;
	logic run;
	logic reload_mode;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// [R7] One wrap per 65536-reload ticks
	tmrtog_edge u_edge (
		.count_i(cnt_reg),
		.reload_i(rld_reg),
		.down_i(cfg_reg[CFG_DOWN]),
		.count_next_o(step_cnt),
		.wrap_o(wrap)
	);

	// [R5] Only reload mode counts; software clears selects
	assign reload_mode = !ctrl_reg[CTRL_CR_SEL] && !ctrl_reg[CTRL_TC_SEL];
	assign run = ctrl_reg[CTRL_RUN] && reload_mode;

	always_comb begin
		ctrl_next = ctrl_reg;
		cfg_next = cfg_reg;
		rld_next = rld_reg;
		cnt_next = cnt_reg;
		rdata_next = 8'h00;
		// [R8] Count only while running
		if (run) begin
			cnt_next = step_cnt;
		end
		// [R10] No toggle while stopped
		// [R2] Toggle on every wrap without a same-cycle config write, held when stopped
		if (run && wrap) begin
			cfg_next[CFG_TOG] = !cfg_reg[CFG_TOG];
			ctrl_next[CTRL_OVF] = 1'b1;
		end
		if (wr_i) begin
			if (hit(addr_i, OFF_CTRL)) begin
				// Wrap flag set wins over software clear
				ctrl_next = {wdata_i[CTRL_OVF] | (run && wrap), 4'h0,
					wdata_i[2:0]};
			end
			// [R9] Write forces toggle level
			if (hit(addr_i, OFF_CFG)) begin
				cfg_next = {5'h00, wdata_i[2:0]};
			end
			if (hit(addr_i, OFF_RLD_LO)) begin
				rld_next[7:0] = wdata_i;
			end
			if (hit(addr_i, OFF_RLD_HI)) begin
				rld_next[15:8] = wdata_i;
			end
			if (hit(addr_i, OFF_CNT_LO)) begin
				cnt_next[7:0] = wdata_i;
			end
			if (hit(addr_i, OFF_CNT_HI)) begin
				cnt_next[15:8] = wdata_i;
			end
		end
		if (rd_i) begin
			case (addr_i)
				OFF_CTRL: rdata_next = ctrl_reg;
				// [R9] Read returns present toggle level
				OFF_CFG: rdata_next = cfg_reg;
				OFF_RLD_LO: rdata_next = rld_reg[7:0];
				OFF_RLD_HI: rdata_next = rld_reg[15:8];
				OFF_CNT_LO: rdata_next = cnt_reg[7:0];
				OFF_CNT_HI: rdata_next = cnt_reg[15:8];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// [R6] Pin follows toggle state only when enabled
	always_comb begin
		pin_next = cfg_next[CFG_TOG] && cfg_next[CFG_OUT_EN];
		oe_next = cfg_next[CFG_OUT_EN];
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= CTRL_RST;
			cfg_reg <= CFG_RST;
			rld_reg <= RLD_RST;
			cnt_reg <= RLD_RST;
			rdata_reg <= 8'h00;
			pin_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			cfg_reg <= cfg_next;
			rld_reg <= rld_next;
			cnt_reg <= cnt_next;
			rdata_reg <= rdata_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
		end
	end

	assign rdata_o = rdata_reg;
	// [R1] Dedicated toggle pin
	assign toggle_pin_a_o = pin_reg;
	assign toggle_pin_a_oe_o = oe_reg;

	sequence s_wrap;
		run && wrap && !(wr_i && addr_i == OFF_CFG);
	endsequence

	AST_TOGGLE_ON_WRAP: assert property (@(posedge core_clk_i) // [R2]
		disable iff (!rst_n_i)
		s_wrap |=> cfg_reg[CFG_TOG] != $past(cfg_reg[CFG_TOG]))
		else $error("toggle missed wrap");
	AST_HOLD_STOPPED: assert property (@(posedge core_clk_i) // [R10]
		disable iff (!rst_n_i)
		(!run && !(wr_i && addr_i == OFF_CFG)) |=> $stable(cfg_reg[CFG_TOG]))
		else $error("toggle changed while stopped");
	AST_DOWN_RELOAD: assert property (@(posedge core_clk_i) // [R3]
		disable iff (!rst_n_i)
		(run && wrap && cfg_reg[CFG_DOWN] && !wr_i) |=> cnt_reg == CNT_TOP)
		else $error("down reload not 0xFFFF");
	AST_UP_RELOAD: assert property (@(posedge core_clk_i) // [R4]
		disable iff (!rst_n_i)
		(run && cnt_reg == CNT_TOP && !cfg_reg[CFG_DOWN] && !wr_i)
		|=> cnt_reg == $past(rld_reg))
		else $error("up reload wrong");
	AST_PIN_GATED: assert property (@(posedge core_clk_i) // [R6]
		disable iff (!rst_n_i)
		!cfg_reg[CFG_OUT_EN] |-> !toggle_pin_a_o && !toggle_pin_a_oe_o)
		else $error("pin driven while disabled");
	AST_PIN_FOLLOWS: assert property (@(posedge core_clk_i) // [R1]
		disable iff (!rst_n_i)
		cfg_reg[CFG_OUT_EN] |-> toggle_pin_a_o == cfg_reg[CFG_TOG])
		else $error("pin not toggle level");
	AST_RUN_COUNTS: assert property (@(posedge core_clk_i) // [R8]
		disable iff (!rst_n_i)
		(run && !wrap && !wr_i && !cfg_reg[CFG_DOWN])
		|=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
		else $error("no count while running");
	AST_READ_TOG: assert property (@(posedge core_clk_i) // [R9]
		disable iff (!rst_n_i)
		(rd_i && addr_i == OFF_CFG)
		|=> rdata_o[CFG_TOG] == $past(cfg_reg[CFG_TOG]))
		else $error("read toggle level wrong");
	AST_MODE_GATE: assert property (@(posedge core_clk_i) // [R5]
		disable iff (!rst_n_i)
		(ctrl_reg[CTRL_CR_SEL] && !wr_i) |=> $stable(cnt_reg))
		else $error("counted outside reload mode");
	AST_PERIOD: assert property (@(posedge core_clk_i) // [R7]
		disable iff (!rst_n_i)
		(run && wrap && !cfg_reg[CFG_DOWN] && rld_reg == 16'hFFFE && !wr_i)
		##1 (run && !wr_i) ##1 (run && !wr_i)
		|-> $past(cfg_reg[CFG_TOG], 2) != cfg_reg[CFG_TOG])
		else $error("period mismatch");
	AST_WRAP_FLAG: assert property (@(posedge core_clk_i) // [R2]
		disable iff (!rst_n_i)
		(run && wrap) |=> ctrl_reg[CTRL_OVF])
		else $error("wrap flag not set");
	AST_DOWN_COUNTS: assert property (@(posedge core_clk_i) // [R3]
		disable iff (!rst_n_i)
		(run && !wrap && !wr_i && cfg_reg[CFG_DOWN])
		|=> cnt_reg == 16'($past(cnt_reg) - 16'h0001))
		else $error("no down count while running");
	AST_OE_FOLLOWS: assert property (@(posedge core_clk_i) // [R6]
		disable iff (!rst_n_i)
		cfg_reg[CFG_OUT_EN] |-> toggle_pin_a_oe_o)
		else $error("output enable not driven");
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench
	import tmrtog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wr, rd, pin, oe, p;
	logic rd_d = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [7:0] exp_q[$];
	logic [15:0] rl;
	int miscompares, cmp_count, cycles = 0;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	tmrtog_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.toggle_pin_a_o(pin), .toggle_pin_a_oe_o(oe));
	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task rd_reg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Interval between two pin changes, bounded
	task half(input logic [15:0] n, input string nm);
		int c;
		for (int k = 0; k < 2; k++) begin
			c = 0;
			p = pin;
			while (pin === p && c < 300) begin
				@(posedge clk);
				#1;
				c++;
			end
		end
		chk(nm, c[15:0], n);
	endtask
	task hold(input string nm);
		p = pin;
		repeat (40) @(posedge clk);
		#1;
		chk(nm, {15'h0, pin}, {15'h0, p});
	endtask
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d === 1'b1)
			chk("rdata", {8'h0, rdata}, {8'h0, exp_q.pop_front()});
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		rst_n = 1'b0;
		{wr, rd, addr, wdata} = '0;
		void'($urandom(32'h15CD));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(OFF_CTRL, CTRL_RST);
		rd_reg(OFF_CFG, CFG_RST);
		rd_reg(OFF_RLD_LO, RLD_RST[7:0]);
		rd_reg(OFF_RLD_HI, RLD_RST[15:8]);
		rd_reg(3'h6, 8'h00);
		chk("oe_rst", {15'h0, oe}, 16'h0000);
		wr_reg(OFF_CFG, 8'h06);
		chk("pin_force", {14'h0, oe, pin}, 16'h0003);
		rd_reg(OFF_CFG, 8'h06);
		wr_reg(OFF_CFG, 8'h02);
		chk("pin_low", {15'h0, pin}, 16'h0000);
		$display("test reset_force done");
		// Random reload, a two-tick period, then the one-tick boundary
		for (int i = 0; i < 3; i++) begin
			rl = (i == 2) ? 16'hFFFF : (i == 1) ? 16'hFFFE :
				{13'h1FFE, 3'($urandom)};
			wr_reg(OFF_RLD_LO, rl[7:0]);
			wr_reg(OFF_RLD_HI, rl[15:8]);
			// Count starts at the reload so the first wrap comes soon
			wr_reg(OFF_CNT_LO, rl[7:0]);
			wr_reg(OFF_CNT_HI, rl[15:8]);
			wr_reg(OFF_CTRL, 8'h04);
			half(16'h0 - rl, "up_half");
			wr_reg(OFF_CTRL, 8'h00);
		end
		hold("stop_hold");
		// Wrap fell on the stopping write: the set wins
		rd_reg(OFF_CTRL, 8'h80);
		wr_reg(OFF_CTRL, 8'h00);
		rd_reg(OFF_CTRL, 8'h00);
		wr_reg(OFF_CFG, {5'h0, ~p, 2'b10});
		chk("pin_set", {15'h0, pin}, {15'h0, ~p});
		rd_reg(OFF_CFG, {5'h0, ~p, 2'b10});
		$display("test up_stop done");
		rl = {13'h1FFE, 3'($urandom)};
		wr_reg(OFF_RLD_LO, rl[7:0]);
		wr_reg(OFF_CFG, 8'h03);
		wr_reg(OFF_CTRL, 8'h04);
		half(16'h0 - rl, "down_half");
		// Select bits set keep the timer from counting
		wr_reg(OFF_CTRL, 8'h05);
		hold("crsel_hold");
		wr_reg(OFF_CTRL, 8'h06);
		hold("tcsel_hold");
		wr_reg(OFF_CFG, 8'h04);
		chk("oe_off", {14'h0, oe, pin}, 16'h0000);
		rd_reg(OFF_CFG, 8'h04);
		$display("test down_select done");
		repeat (3) @(posedge clk);
		complete_run();
	end
endmodule
`default_nettype wire
